//--- sync_burst_sram_port_consts.vh
/*
 Constants for the synchronous flow-through burst SRAM front end.
 Assumes it is included by its bare name from the design file.
*/
`ifndef SYNC_BURST_SRAM_PORT_CONSTS_VH
`define SYNC_BURST_SRAM_PORT_CONSTS_VH

// Address width: 256K locations
`define SBS_ADDR_W 18
// Depth of the array
`define SBS_DEPTH 262144
// Byte lanes, data bits per lane, total data bits
`define SBS_LANES 4
`define SBS_LANE_W 8
`define SBS_DATA_W 32
// Burst counter width and burst order pin levels
`define SBS_BCNT_W 2
`define SBS_ORDER_LINEAR 1'b0
`define SBS_ORDER_INTERLEAVED 1'b1
// Reset values
`define SBS_CNT_RST 2'h0
`define SBS_ADDR_RST 16'h0000

`endif

//--- sync_burst_sram_port.v
/*
 Front end and array of a synchronous flow-through burst SRAM with
 two address strobes, three chip selects, lane and global writes,
 a 2-bit burst counter and an asynchronous output enable.
 Assumes every input except out_enable_n_i and sys_rst_i is synchronous to ref_clk_i,
 and that the bus master keeps its own timing rules.
 Assumes the surroundings turn data_oe_n_o into the enable of the
 shared data and parity pins, and feed the pin values back on data_i.
 The array itself has no reset; words read before written are unknown.
 The control state has an asynchronous reset that leaves it deselected.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sync_burst_sram_port_consts.vh"

module sync_burst_sram_port (
   input wire ref_clk_i,
   input wire sys_rst_i,
   input wire [`SBS_ADDR_W-1:0] addr_i,
   input wire chip_sel_primary_n_i,
   input wire chip_sel_second_i,
   input wire chip_sel_third_n_i,
   input wire proc_addr_strobe_n_i,
   input wire ctrl_addr_strobe_n_i,
   input wire burst_advance_n_i,
   input wire lane_write_enable_n_i,
   input wire [`SBS_LANES-1:0] byte_lane_select_n_i,
   input wire all_lanes_write_n_i,
   input wire out_enable_n_i,
   input wire burst_order_i,
   input wire [`SBS_DATA_W-1:0] data_i,
   input wire [`SBS_LANES-1:0] parity_lanes_i,
   output wire [`SBS_DATA_W-1:0] data_o,
   output wire [`SBS_LANES-1:0] parity_lanes_o,
   output wire data_oe_n_o
);

   localparam WORD_W = `SBS_DATA_W + `SBS_LANES;
   localparam LW = `SBS_LANE_W + 1;

   // ----------------------------------------------------------------
   // Burst address
   // ----------------------------------------------------------------
   function [`SBS_BCNT_W-1:0] burst_low;
      input [`SBS_BCNT_W-1:0] seed;
      input [`SBS_BCNT_W-1:0] step;
      input order;
      begin
         if (order == `SBS_ORDER_INTERLEAVED) begin
            burst_low = seed ^ step;
         end else begin
            burst_low = seed + step;
         end
      end
   endfunction

   // ----------------------------------------------------------------
   // State and next state
   // ----------------------------------------------------------------
   reg [WORD_W-1:0] mem [0:`SBS_DEPTH-1];
   reg [`SBS_ADDR_W-3:0] addr_hi_ff;
   reg [`SBS_BCNT_W-1:0] seed_ff;
   reg [`SBS_BCNT_W-1:0] step_ff;
   reg sel_ff;
   reg first_ff;
   reg wr_ff;
   reg [`SBS_ADDR_W-3:0] nxt_addr_hi;
   reg [`SBS_BCNT_W-1:0] nxt_seed;
   reg [`SBS_BCNT_W-1:0] nxt_step;
   reg nxt_sel;
   reg nxt_first;
   reg nxt_wr;
   reg [`SBS_LANES-1:0] lane_wr;

   // ----------------------------------------------------------------
   // Cycle decode
   // ----------------------------------------------------------------
   wire selected = ~chip_sel_primary_n_i & chip_sel_second_i &
      ~chip_sel_third_n_i;
   wire proc_go = ~proc_addr_strobe_n_i & ~chip_sel_primary_n_i;
   wire ctrl_go = ~ctrl_addr_strobe_n_i & ~proc_go;

   // ----------------------------------------------------------------
   // Lane write requests
   // ----------------------------------------------------------------
   wire [`SBS_LANES-1:0] lane_req = {`SBS_LANES{~all_lanes_write_n_i}} |
      ({`SBS_LANES{~lane_write_enable_n_i}} & ~byte_lane_select_n_i);

   // ----------------------------------------------------------------
   // Burst position
   // ----------------------------------------------------------------
   wire [`SBS_BCNT_W-1:0] cur_low = burst_low(seed_ff, step_ff,
      burst_order_i);
   wire [`SBS_BCNT_W-1:0] acc_low = burst_low(nxt_seed, nxt_step,
      burst_order_i);
   wire [`SBS_ADDR_W-1:0] cur_addr = {addr_hi_ff, cur_low};
   wire [`SBS_ADDR_W-1:0] acc_addr = {nxt_addr_hi, acc_low};

   always @* begin
      nxt_addr_hi = addr_hi_ff;
      nxt_seed = seed_ff;
      nxt_step = step_ff;
      nxt_sel = sel_ff;
      nxt_first = 1'b0;
      nxt_wr = 1'b0;
      if (proc_go) begin
         nxt_sel = selected;
         nxt_first = selected & ~sel_ff;
         if (selected) begin
            nxt_addr_hi = addr_i[`SBS_ADDR_W-1:2];
            nxt_seed = addr_i[1:0];
            nxt_step = `SBS_CNT_RST;
         end
      end else if (ctrl_go) begin
         nxt_sel = selected;
         nxt_first = selected & ~sel_ff;
         if (selected) begin
            nxt_addr_hi = addr_i[`SBS_ADDR_W-1:2];
            nxt_seed = addr_i[1:0];
            nxt_step = `SBS_CNT_RST;
            nxt_wr = |lane_req;
         end
      end else if (sel_ff) begin
         if (~burst_advance_n_i) begin
            nxt_step = step_ff + 2'h1;
         end
         nxt_wr = |lane_req;
      end
   end

   // ----------------------------------------------------------------
   // Lane write strobes
   // ----------------------------------------------------------------
   always @* begin
      lane_wr = {`SBS_LANES{1'b0}};
      if (nxt_wr) begin
         lane_wr = lane_req;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_hi_ff <= `SBS_ADDR_RST;
         seed_ff <= `SBS_CNT_RST;
         step_ff <= `SBS_CNT_RST;
         sel_ff <= 1'b0;
         first_ff <= 1'b0;
         wr_ff <= 1'b0;
      end else begin
         addr_hi_ff <= nxt_addr_hi;
         seed_ff <= nxt_seed;
         step_ff <= nxt_step;
         sel_ff <= nxt_sel;
         first_ff <= nxt_first;
         wr_ff <= nxt_wr;
      end
   end

   // ----------------------------------------------------------------
   // Array write, lane by lane in one process
   // ----------------------------------------------------------------
   integer n;
   always @(posedge ref_clk_i) begin
      for (n = 0; n < `SBS_LANES; n = n + 1) begin
         if (lane_wr[n]) begin
            mem[acc_addr][n*LW +: LW] <= {parity_lanes_i[n],
               data_i[n*`SBS_LANE_W +: `SBS_LANE_W]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path and pin direction
   // ----------------------------------------------------------------
   genvar g;
   wire [WORD_W-1:0] rd_word = mem[cur_addr];
   generate
      for (g = 0; g < `SBS_LANES; g = g + 1) begin : rd
         assign data_o[g*`SBS_LANE_W +: `SBS_LANE_W] =
            rd_word[g*LW +: `SBS_LANE_W];
         assign parity_lanes_o[g] = rd_word[g*LW + `SBS_LANE_W];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Output enable masking
   // ----------------------------------------------------------------
   // Float while deselected
   wire mask_desel = ~sel_ff;
   // Float in the first cycle out of deselect
   wire mask_first = first_ff;
   // Float in the cycle after write data is taken
   wire mask_write = wr_ff;
   // Drive asked for by the asynchronous enable
   wire drive_req = ~out_enable_n_i;

   // Low while the pins are driven
   assign data_oe_n_o = ~(drive_req & ~mask_desel & ~mask_first &
      ~mask_write);

endmodule
`default_nettype wire

//--- sync_burst_sram_port_chk.sv
/* Port checker for the burst SRAM front end.
   Assumes a bind from tb onto sync_burst_sram_port. */
`timescale 1ns/1ns
`default_nettype none
`include "sync_burst_sram_port_consts.vh"
module sync_burst_sram_port_chk (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic chip_sel_primary_n_i,
   input wire logic chip_sel_second_i,
   input wire logic chip_sel_third_n_i,
   input wire logic proc_addr_strobe_n_i,
   input wire logic ctrl_addr_strobe_n_i,
   input wire logic burst_advance_n_i,
   input wire logic lane_write_enable_n_i,
   input wire logic all_lanes_write_n_i,
   input wire logic out_enable_n_i,
   input wire logic [`SBS_DATA_W-1:0] data_o,
   input wire logic data_oe_n_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   wire sel = !chip_sel_primary_n_i && chip_sel_second_i;
   wire sel3 = sel && !chip_sel_third_n_i;
   wire ps = !proc_addr_strobe_n_i && !chip_sel_primary_n_i;
   wire cs = !ctrl_addr_strobe_n_i && !ps;
   wire quiet = proc_addr_strobe_n_i && ctrl_addr_strobe_n_i &&
      all_lanes_write_n_i && lane_write_enable_n_i;
   wire ign = !proc_addr_strobe_n_i && chip_sel_primary_n_i &&
      ctrl_addr_strobe_n_i && burst_advance_n_i &&
      all_lanes_write_n_i && lane_write_enable_n_i;
   chk_oe_release: assert property (out_enable_n_i |-> data_oe_n_o)
      else $error("pins driven with enable high");
   chk_write_float: assert property (
      cs && sel3 && !all_lanes_write_n_i |=> data_oe_n_o)
      else $error("pins driven in write cycle");
   chk_desel_proc: assert property (ps && !sel3 |=> data_oe_n_o)
      else $error("pins driven after deselect");
   chk_desel_ctrl: assert property (cs && !sel3 |=> data_oe_n_o)
      else $error("pins driven after deselect");
   chk_first_read: assert property (
      ps && !sel3 ##1 ps && sel3 |=> data_oe_n_o)
      else $error("enable not masked in first read");
   chk_burst_drive: assert property (
      ps && sel3 ##1 quiet && !burst_advance_n_i
      |=> out_enable_n_i || !data_oe_n_o)
      else $error("burst read not driven");
   chk_proc_ignored: assert property (
      ps && sel3 ##1 ign |=> out_enable_n_i || !data_oe_n_o)
      else $error("ignored strobe acted on");
   chk_data_hold: assert property (
      ps && sel3 ##1 quiet && burst_advance_n_i |=> $stable(data_o))
      else $error("read data moved while idle");
endmodule
`default_nettype wire

//--- bus_master_model.sv
/* Processor bus model for the burst SRAM front end.
   Assumes the bench calls cyc once for each clock. */
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
   input wire logic ref_clk_i,
   output logic [11:0] ctl_o,
   output logic [17:0] addr_o,
   output logic [35:0] wd_o
);
   initial begin
      ctl_o = 12'h5ff;
      addr_o = 18'h00000;
      wd_o = 36'h000000000;
   end
   // Drives one cycle; data bus toggles when no write is asked
   task cyc(input logic [11:0] c, input logic [17:0] a, input logic [35:0] d);
      @(posedge ref_clk_i);
      #2;
      ctl_o = c;
      addr_o = a;
      wd_o = (c[5] && (c[4] || &c[3:0])) ? ~wd_o : d;
   endtask
endmodule
`default_nettype wire

//--- tb.sv
/* Self-checking bench for the burst SRAM front end.
   Assumes the design, checker and bus model files compile first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) comparisons++; if ((a) !== (e)) begin \
   mismatches++; $display("mismatch %s exp %h seen %h", n, e, a); end
module tb;
   logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, oe_n = 1'b1, order = 1'b0;
   logic [11:0] ctl;
   logic [17:0] addr, a;
   logic [35:0] wd, d;
   logic [37:0] e;
   logic [3:0] l, par_o;
   logic [31:0] data_o;
   logic oe_o;
   int mismatches = 0, comparisons = 0;
   logic [35:0] m [bit [17:0]];
   logic [37:0] q [$];
   always #20 ref_clk_i = ~ref_clk_i;
   bus_master_model u_bus_master_model (.ref_clk_i(ref_clk_i),
      .ctl_o(ctl), .addr_o(addr), .wd_o(wd));
   sync_burst_sram_port u_sync_burst_sram_port (.ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i), .addr_i(addr), .chip_sel_primary_n_i(ctl[11]),
      .chip_sel_second_i(ctl[10]), .chip_sel_third_n_i(ctl[9]),
      .proc_addr_strobe_n_i(ctl[8]), .ctrl_addr_strobe_n_i(ctl[7]),
      .burst_advance_n_i(ctl[6]), .all_lanes_write_n_i(ctl[5]),
      .lane_write_enable_n_i(ctl[4]), .byte_lane_select_n_i(ctl[3:0]),
      .out_enable_n_i(oe_n), .burst_order_i(order), .data_i(wd[31:0]),
      .parity_lanes_i(wd[35:32]), .data_o(data_o), .parity_lanes_o(par_o),
      .data_oe_n_o(oe_o));
   function logic [17:0] ba(logic [17:0] x, int k);
      return {x[17:2], order ? x[1:0] ^ k[1:0] : x[1:0] + k[1:0]};
   endfunction
   task results;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge ref_clk_i) if (q.size() > 0) begin
      @(negedge ref_clk_i);
      e = q.pop_front();
      `CHK("word", e[35:0], {par_o, data_o})
      if (e[37]) begin `CHK("oe", e[36], oe_o) end
   end
   initial begin
      void'($urandom(63));
      repeat (10) @(posedge ref_clk_i);
      #2 sys_rst_i = 1'b0;
      @(posedge ref_clk_i);
      #2 oe_n = 1'b0;
      for (int o = 0; o < 2; o++) begin
         repeat (2) @(posedge ref_clk_i);
         #2 order = o[0];
         a = 18'($urandom);
         for (int k = 0; k < 4; k++) begin
            d = 36'({$urandom, $urandom});
            m[ba(a, k)] = d;
            u_bus_master_model.cyc(k ? 12'h59f : 12'h55f, a, d);
            q.push_back({2'b11, d});
         end
         u_bus_master_model.cyc(12'h0ff, a, d);
         for (int k = 0; k < 5; k++) begin
            u_bus_master_model.cyc(k == 0 ? 12'h4ff :
               k == 4 ? 12'h5ff : 12'h5bf, a, d);
            q.push_back({1'b1, k == 0, m[ba(a, k == 4 ? 3 : k)]});
         end
      end
      for (int k = 0; k < 2; k++) begin
         l = 4'($urandom);
         d = 36'({$urandom, $urandom});
         for (int g = 0; g < 4; g++) if (!k[0] && !l[g]) begin
            m[a][8*g +: 8] = d[8*g +: 8];
            m[a][32+g] = d[32+g];
         end
         u_bus_master_model.cyc({7'h2b, k[0], l}, a, d);
         q.push_back({1'b1, !k[0] && l != 4'hf, m[a]});
      end
      u_bus_master_model.cyc(12'h4ff, a, d);
      q.push_back({2'b10, m[a]});
      u_bus_master_model.cyc(12'hcff, a ^ 18'h00003, d);
      q.push_back({2'b10, m[a]});
      u_bus_master_model.cyc(12'h45f, a, ~m[a]);
      q.push_back({2'b10, m[a]});
      u_bus_master_model.cyc(12'h5ff, a, d);
      q.push_back({2'b10, m[a]});
      u_bus_master_model.cyc(12'h17f, a, d);
      repeat (3) @(posedge ref_clk_i);
      results();
   end
   initial begin
      #20000;
      mismatches++;
      results();
   end
endmodule
bind sync_burst_sram_port sync_burst_sram_port_chk u_chk (.*);
`default_nettype wire
